/* design/bgcs_consts.vh */
`ifndef BGCS_CONSTS_VH
`define BGCS_CONSTS_VH

// Host clock period in picoseconds (200 MHz).
`define BGCS_MCLK_PS 5000
// Host clocks per memory command clock; the memory clock is mclk divided by this.
`define BGCS_CK_DIV 4
// Host clock count at which the divided clock falls (high for counts below it).
`define BGCS_CK_HALF 2

// Command codes on the request port and on the command pins.
`define BGCS_CMD_ACT 2'h0
`define BGCS_CMD_RD 2'h1
`define BGCS_CMD_WR 2'h2
`define BGCS_CMD_OTHER 2'h3

// Burst length modes.
`define BGCS_BL_FIXED8 2'h0
`define BGCS_BL_OTF 2'h1
`define BGCS_BL_FIXED4 2'h2

// Clock-count parts of the spacings, in memory clocks.
`define BGCS_CCDS_NCK 8'h04
`define BGCS_CCDL_NCK 8'h04
`define BGCS_RRDS_NCK 8'h04
`define BGCS_RRDL_NCK 8'h04
`define BGCS_WTRS_NCK 8'h02
`define BGCS_WTRL_NCK 8'h04

// Absolute-time floors of the spacings, in picoseconds.
`define BGCS_CCDS_PS 0
`define BGCS_CCDL_PS 6250
`define BGCS_RRDS_PS 5000
`define BGCS_RRDL_PS 6000
`define BGCS_WTRS_PS 2500
`define BGCS_WTRL_PS 7500

// Least times round up to whole host clocks.
`define BGCS_PS2CYC(ps) (((ps) + `BGCS_MCLK_PS - 1) / `BGCS_MCLK_PS)

// Burst lengths in beats.
`define BGCS_BURST8 8'h08
`define BGCS_BURST4 8'h04

`endif

/* design/bgcs_ckgen.v */
// Divides the host clock down to the memory command clock and marks its falling edge.
module bgcs_ckgen (
   input wire mclk,
   input wire rst,
   output reg ck_reg,
   output reg ck_fall_reg
);

`include "bgcs_consts.vh"

   // Counter end points cut to the counter's width on purpose.
   localparam integer CNT_LAST_I = `BGCS_CK_DIV - 1;
   localparam integer CNT_HALF_I = `BGCS_CK_HALF;
   localparam [1:0] CNT_LAST = CNT_LAST_I[1:0];
   localparam [1:0] CNT_HALF = CNT_HALF_I[1:0];

   reg [1:0] cnt_reg;
   wire [1:0] cnt_next;

   assign cnt_next = (cnt_reg == CNT_LAST) ? 2'h0 : cnt_reg + 2'h1;

   // The fall mark lets the controller change pins one host clock (a quarter memory clock) before the rising edge.
   always @(posedge mclk) begin
      if (rst) begin
         cnt_reg <= 2'h0;
         ck_reg <= 1'b0;
         ck_fall_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         ck_reg <= (cnt_next < CNT_HALF);
         ck_fall_reg <= (cnt_next == CNT_HALF);
      end
   end

endmodule // bgcs_ckgen

/* design/bgcs_ctrl.v */
// Summary of operation
// [R1] The x8 memory has four groups by two group bits, four banks each.
// [R2] The x16 memory has two groups by one group bit, four banks each.
// [R3] Column commands to different groups are spaced at least the short column delay.
// [R4] Column commands within one group are spaced at least the long column delay.
// [R5] Activates to different groups are spaced at least the short activate period.
// [R6] Activates within one group are spaced at least the long activate period.
// [R7] A read to another group waits the short write-to-read delay after write.
// [R8] A read to the same group waits the long write-to-read delay after write.
// [R9] Where clocks and time both apply, the larger of the two is kept.
// [R10] Read to write waits CL minus CWL plus half burst, one clock, preamble.
// [R11] Write to read waits CWL plus half write burst plus write-to-read delay.
// [R12] Read burst counts eight for length-eight reads and four for chopped reads.
// [R13] Track last commands per group and hold any command until spacings elapse.
module bgcs_ctrl (
   input wire mclk,
   input wire rst,
   input wire [4:0] cfg_cl,
   input wire [4:0] cfg_cwl,
   input wire cfg_wpre2,
   input wire [1:0] cfg_bl_mode,
   input wire cfg_x16,
   input wire req_valid,
   output reg req_ready_reg,
   input wire [1:0] req_cmd,
   input wire [1:0] req_bg,
   input wire [1:0] req_ba,
   input wire req_bc4,
   output wire dram_ck,
   output reg dram_cmd_valid_reg,
   output reg [1:0] dram_cmd_reg,
   output reg [1:0] dram_bg_reg,
   output reg [1:0] dram_ba_reg,
   output reg dram_a12_reg,
   output reg cmd_issued_reg
);

`include "bgcs_consts.vh"

   // Time floors as host clock counts.
   localparam integer CCDS_FLOOR_I = `BGCS_PS2CYC(`BGCS_CCDS_PS);
   localparam integer CCDL_FLOOR_I = `BGCS_PS2CYC(`BGCS_CCDL_PS);
   localparam integer RRDS_FLOOR_I = `BGCS_PS2CYC(`BGCS_RRDS_PS);
   localparam integer RRDL_FLOOR_I = `BGCS_PS2CYC(`BGCS_RRDL_PS);
   localparam integer WTRS_FLOOR_I = `BGCS_PS2CYC(`BGCS_WTRS_PS);
   localparam integer WTRL_FLOOR_I = `BGCS_PS2CYC(`BGCS_WTRL_PS);
   localparam integer CK_DIV_I = `BGCS_CK_DIV;
   // The integer results are cut to the timer width on purpose; all of them fit.
   localparam [7:0] CCDS_FLOOR = CCDS_FLOOR_I[7:0];
   localparam [7:0] CCDL_FLOOR = CCDL_FLOOR_I[7:0];
   localparam [7:0] RRDS_FLOOR = RRDS_FLOOR_I[7:0];
   localparam [7:0] RRDL_FLOOR = RRDL_FLOOR_I[7:0];
   localparam [7:0] WTRS_FLOOR = WTRS_FLOOR_I[7:0];
   localparam [7:0] WTRL_FLOOR = WTRL_FLOOR_I[7:0];
   localparam [7:0] CK_DIV8 = CK_DIV_I[7:0];

   // Larger of two counts.
   function [7:0] bgcs_max;
      input [7:0] a;
      input [7:0] b;
      begin
         bgcs_max = (a > b) ? a : b;
      end
   endfunction

   // A spacing in host clocks: clock count scaled by the divider, never below the time floor.
   function [7:0] bgcs_span;
      input [7:0] nck;
      input [7:0] floor_cyc;
      begin
         bgcs_span = bgcs_max(nck * CK_DIV8, floor_cyc); // [R9]
      end
   endfunction

   // One step of a countdown that stops at zero.
   function [7:0] bgcs_dec;
      input [7:0] t;
      begin
         bgcs_dec = (t == 8'h00) ? 8'h00 : t - 8'h01;
      end
   endfunction

   // Group address as the memory sees it; the x16 part has no upper group bit.
   function [1:0] bgcs_grp;
      input [1:0] bg;
      input x16;
      begin
         bgcs_grp = {bg[1] & ~x16, bg[0]}; // [R1] [R2]
      end
   endfunction

   wire ck_fall;
   reg hold_full_reg;
   reg [1:0] hold_cmd_reg;
   reg [1:0] hold_bg_reg;
   reg [1:0] hold_ba_reg;
   reg hold_bc4_reg;
   reg [7:0] col_tmr_reg [0:3];
   reg [7:0] act_tmr_reg [0:3];
   reg [7:0] rd_tmr_reg [0:3];
   reg [7:0] wr_tmr_reg;
   reg legal;
   reg issue;
   reg hold_full_next;
   reg [1:0] grp;
   reg chop;
   reg [7:0] wbl;
   reg [7:0] rbl;
   reg [7:0] wr_base;
   reg [7:0] r2w_nck;
   reg [7:0] r2w_span;
   wire [7:0] ccds;
   wire [7:0] ccdl;
   wire [7:0] rrds;
   wire [7:0] rrdl;
   wire [7:0] wtrs;
   wire [7:0] wtrl;
   integer g;

   bgcs_ckgen u_ckgen (
      .mclk(mclk),
      .rst(rst),
      .ck_reg(dram_ck),
      .ck_fall_reg(ck_fall)
   );

   assign ccds = bgcs_span(`BGCS_CCDS_NCK, CCDS_FLOOR); // [R3]
   assign ccdl = bgcs_span(`BGCS_CCDL_NCK, CCDL_FLOOR); // [R4]
   assign rrds = bgcs_span(`BGCS_RRDS_NCK, RRDS_FLOOR); // [R5]
   assign rrdl = bgcs_span(`BGCS_RRDL_NCK, RRDL_FLOOR); // [R6]
   assign wtrs = bgcs_span(`BGCS_WTRS_NCK, WTRS_FLOOR); // [R7]
   assign wtrl = bgcs_span(`BGCS_WTRL_NCK, WTRL_FLOOR); // [R8]

   // Burst lengths, the read-to-write figure and the legality of the held command.
   always @* begin
      grp = bgcs_grp(hold_bg_reg, cfg_x16);
      chop = (cfg_bl_mode == `BGCS_BL_FIXED4) || ((cfg_bl_mode == `BGCS_BL_OTF) && hold_bc4_reg);
      rbl = chop ? `BGCS_BURST4 : `BGCS_BURST8; // [R12]
      // A write counts as eight beats unless the chop is fixed in the mode.
      wbl = (cfg_bl_mode == `BGCS_BL_FIXED4) ? `BGCS_BURST4 : `BGCS_BURST8; // [R11]
      wr_base = ({3'h0, cfg_cwl} + (wbl >> 1)) * CK_DIV8; // [R11]
      r2w_nck = {3'h0, cfg_cl} + (rbl >> 1) + 8'h01 + (cfg_wpre2 ? 8'h02 : 8'h01); // [R10]
      // A CWL above the rest would wrap, so the spacing falls back to one clock.
      if (r2w_nck > {3'h0, cfg_cwl}) begin
         r2w_span = (r2w_nck - {3'h0, cfg_cwl}) * CK_DIV8; // [R10]
      end else begin
         r2w_span = CK_DIV8;
      end
      case (hold_cmd_reg)
         `BGCS_CMD_ACT: legal = (act_tmr_reg[grp] == 8'h00); // [R13]
         `BGCS_CMD_RD: legal = (col_tmr_reg[grp] == 8'h00) && (rd_tmr_reg[grp] == 8'h00); // [R13]
         `BGCS_CMD_WR: legal = (col_tmr_reg[grp] == 8'h00) && (wr_tmr_reg == 8'h00); // [R13]
         default: legal = 1'b1;
      endcase
      issue = ck_fall && hold_full_reg && legal;
      hold_full_next = (hold_full_reg && !issue) || (req_valid && req_ready_reg);
   end

   // One-deep hold: a request waits here until its spacings allow it onto the pins.
   always @(posedge mclk) begin
      if (rst) begin
         hold_full_reg <= 1'b0;
         hold_cmd_reg <= `BGCS_CMD_OTHER;
         hold_bg_reg <= 2'h0;
         hold_ba_reg <= 2'h0;
         hold_bc4_reg <= 1'b0;
         req_ready_reg <= 1'b0;
      end else begin
         hold_full_reg <= hold_full_next;
         req_ready_reg <= !hold_full_next;
         if (req_valid && req_ready_reg) begin
            hold_cmd_reg <= req_cmd;
            hold_bg_reg <= req_bg;
            hold_ba_reg <= req_ba;
            hold_bc4_reg <= req_bc4;
         end
      end
   end

   // Countdowns: an issued command raises them to its spacings, less the cycle just spent.
   always @(posedge mclk) begin
      if (rst) begin
         for (g = 0; g < 4; g = g + 1) begin
            col_tmr_reg[g] <= 8'h00;
            act_tmr_reg[g] <= 8'h00;
            rd_tmr_reg[g] <= 8'h00;
         end
         wr_tmr_reg <= 8'h00;
      end else begin
         for (g = 0; g < 4; g = g + 1) begin
            col_tmr_reg[g] <= bgcs_dec(col_tmr_reg[g]);
            act_tmr_reg[g] <= bgcs_dec(act_tmr_reg[g]);
            rd_tmr_reg[g] <= bgcs_dec(rd_tmr_reg[g]);
            if (issue && (hold_cmd_reg == `BGCS_CMD_ACT)) begin
               act_tmr_reg[g] <= bgcs_max(bgcs_dec(act_tmr_reg[g]),
                                          ((grp == g[1:0]) ? rrdl : rrds) - 8'h01); // [R5] [R6]
            end
            if (issue && ((hold_cmd_reg == `BGCS_CMD_RD) || (hold_cmd_reg == `BGCS_CMD_WR))) begin
               col_tmr_reg[g] <= bgcs_max(bgcs_dec(col_tmr_reg[g]),
                                          ((grp == g[1:0]) ? ccdl : ccds) - 8'h01); // [R3] [R4]
            end
            if (issue && (hold_cmd_reg == `BGCS_CMD_WR)) begin
               rd_tmr_reg[g] <= bgcs_max(bgcs_dec(rd_tmr_reg[g]),
                                         wr_base + ((grp == g[1:0]) ? wtrl : wtrs) - 8'h01); // [R7] [R8] [R11]
            end
         end
         if (issue && (hold_cmd_reg == `BGCS_CMD_RD)) begin
            wr_tmr_reg <= bgcs_max(bgcs_dec(wr_tmr_reg), r2w_span - 8'h01); // [R10]
         end else begin
            wr_tmr_reg <= bgcs_dec(wr_tmr_reg);
         end
      end
   end

   // Pins change just after the clock falls and hold for one whole memory clock.
   always @(posedge mclk) begin
      if (rst) begin
         dram_cmd_valid_reg <= 1'b0;
         dram_cmd_reg <= `BGCS_CMD_OTHER;
         dram_bg_reg <= 2'h0;
         dram_ba_reg <= 2'h0;
         dram_a12_reg <= 1'b1;
         cmd_issued_reg <= 1'b0;
      end else begin
         cmd_issued_reg <= issue;
         if (issue) begin
            dram_cmd_valid_reg <= 1'b1;
            dram_cmd_reg <= hold_cmd_reg;
            dram_bg_reg <= grp;
            dram_ba_reg <= hold_ba_reg;
            dram_a12_reg <= !hold_bc4_reg; // Low selects the chopped burst on the fly.
         end else if (ck_fall) begin
            dram_cmd_valid_reg <= 1'b0;
         end
      end
   end

endmodule // bgcs_ctrl

/* testbench/bgcs_ctrl_checker.sv */
`include "bgcs_consts.vh"
module bgcs_ctrl_checker (
   input logic mclk,
   input logic rst,
   input logic [4:0] cfg_cl,
   input logic [4:0] cfg_cwl,
   input logic cfg_wpre2,
   input logic [1:0] cfg_bl_mode,
   input logic cfg_x16,
   input logic req_valid,
   input logic req_ready_reg,
   input logic dram_cmd_valid_reg,
   input logic [1:0] dram_cmd_reg,
   input logic [1:0] dram_bg_reg,
   input logic dram_a12_reg,
   input logic cmd_issued_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] c_col, c_act, c_wr, c_rd;
   logic [1:0] g_wr;
   logic r4;
   int wtr_min, rtw_min;
   wire rd = dram_cmd_reg == `BGCS_CMD_RD;
   wire wr = dram_cmd_reg == `BGCS_CMD_WR;
   wire go = cmd_issued_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Cycles since each launch class; saturation keeps long idles from wrapping into false gaps.
   always_ff @(posedge mclk) begin
      if (rst) begin
         {c_col, c_act, c_wr, c_rd, g_wr, r4} <= '1;
      end else begin
         c_col <= (go && (rd || wr)) ? 8'h01 : c_col + (c_col != 8'hff);
         c_act <= (go && dram_cmd_reg == `BGCS_CMD_ACT) ? 8'h01 : c_act + (c_act != 8'hff);
         c_wr <= (go && wr) ? 8'h01 : c_wr + (c_wr != 8'hff);
         c_rd <= (go && rd) ? 8'h01 : c_rd + (c_rd != 8'hff);
         if (go && wr) g_wr <= dram_bg_reg;
         if (go && rd) r4 <= cfg_bl_mode == 2'h2 || (cfg_bl_mode == 2'h1 && !dram_a12_reg);
      end
   end
   // Least gaps in host clocks for the turnarounds.
   always_comb begin
      wtr_min = (cfg_cwl + (cfg_bl_mode == 2'h2 ? 2 : 4)) * 4 + (dram_bg_reg == g_wr ? 16 : 8);
      rtw_min = (int'(cfg_cl) - int'(cfg_cwl) + (r4 ? 2 : 4) + 1 + (cfg_wpre2 ? 2 : 1)) * 4;
   end
   sequence quiet_3;
      (!cmd_issued_reg && $stable(dram_cmd_reg) && $stable(dram_bg_reg))[*3];
   endsequence
   ccd_space_a: assert property (go && (rd || wr) |-> c_col >= 8'd16)
      else $error("column gap short");
   rrd_space_a: assert property (go && dram_cmd_reg == `BGCS_CMD_ACT |-> c_act >= 8'd16)
      else $error("activate gap short");
   wtr_space_a: assert property (go && rd |-> int'(c_wr) >= wtr_min)
      else $error("write to read gap short");
   rtw_space_a: assert property (go && wr |-> int'(c_rd) >= rtw_min)
      else $error("read to write gap short");
   one_per_ck_a: assert property (go |=> quiet_3)
      else $error("second launch in one memory clock");
   valid_width_a: assert property (go |-> dram_cmd_valid_reg [*4])
      else $error("command valid too short");
   take_launch_a: assert property (req_valid && req_ready_reg |-> ##[1:200] go)
      else $error("request never launched");
   x16_group_a: assert property (go && cfg_x16 |-> !dram_bg_reg[1])
      else $error("x16 group bit set");
endmodule // bgcs_ctrl_checker
bind bgcs_ctrl bgcs_ctrl_checker i_chk (.mclk(mclk), .rst(rst), .cfg_cl(cfg_cl), .cfg_cwl(cfg_cwl),
   .cfg_wpre2(cfg_wpre2), .cfg_bl_mode(cfg_bl_mode), .cfg_x16(cfg_x16), .req_valid(req_valid),
   .req_ready_reg(req_ready_reg), .dram_cmd_valid_reg(dram_cmd_valid_reg), .dram_cmd_reg(dram_cmd_reg),
   .dram_bg_reg(dram_bg_reg), .dram_a12_reg(dram_a12_reg), .cmd_issued_reg(cmd_issued_reg));

/* testbench/bgcs_mem_model.sv */
module bgcs_mem_model (
   input logic mclk,
   input logic rst,
   input logic x16,
   input logic ck,
   input logic cmd_valid,
   input logic [1:0] bg,
   input logic [1:0] ba,
   output int seen,
   output logic [3:0] bank
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ck_q;
   // Commands are latched on the memory clock's rising edge; x16 parts ignore group bit one.
   always @(posedge mclk) begin
      ck_q <= ck;
      if (rst) begin
         seen <= 0;
      end else if (ck && !ck_q && cmd_valid) begin
         seen <= seen + 1;
         bank <= {x16 ? 1'b0 : bg[1], bg[0], ba};
      end
   end
endmodule // bgcs_mem_model

/* testbench/tb.sv */
`include "bgcs_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, cfg_wpre2, cfg_x16, req_valid, req_bc4;
   logic [4:0] cfg_cl, cfg_cwl;
   logic [1:0] cfg_bl_mode, req_cmd, req_bg, req_ba;
   wire req_ready_reg, dram_ck, dram_cmd_valid_reg, dram_a12_reg, cmd_issued_reg;
   wire [1:0] dram_cmd_reg, dram_bg_reg, dram_ba_reg;
   wire [3:0] bank;
   int seen, n_errors, total_checks, cyc, last, gap, n_iss, i;
   logic [31:0] r, q;
   bgcs_ctrl i_dut (.mclk(mclk), .rst(rst), .cfg_cl(cfg_cl), .cfg_cwl(cfg_cwl), .cfg_wpre2(cfg_wpre2),
      .cfg_bl_mode(cfg_bl_mode), .cfg_x16(cfg_x16), .req_valid(req_valid), .req_ready_reg(req_ready_reg),
      .req_cmd(req_cmd), .req_bg(req_bg), .req_ba(req_ba), .req_bc4(req_bc4), .dram_ck(dram_ck),
      .dram_cmd_valid_reg(dram_cmd_valid_reg), .dram_cmd_reg(dram_cmd_reg), .dram_bg_reg(dram_bg_reg),
      .dram_ba_reg(dram_ba_reg), .dram_a12_reg(dram_a12_reg), .cmd_issued_reg(cmd_issued_reg));
   bgcs_mem_model i_mem (.mclk(mclk), .rst(rst), .x16(cfg_x16), .ck(dram_ck), .cmd_valid(dram_cmd_valid_reg),
      .bg(dram_bg_reg), .ba(dram_ba_reg), .seen(seen), .bank(bank));
   initial begin
      mclk = 0;
      forever #2.5 mclk = ~mclk;
   end
   // Launch gaps in host clocks, sampled mid-cycle once the pins have settled.
   always @(negedge mclk) begin
      cyc++;
      if (cmd_issued_reg === 1'b1) begin
         gap = cyc - last;
         last = cyc;
         n_iss++;
      end
   end
   task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
      total_checks++;
      if (seen_v !== exp_v) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   // Valid stays up across back-to-back sends so it is never lowered and raised in one step.
   task automatic send(input logic [1:0] c, input logic [1:0] g, input logic [1:0] b, input logic k);
      {req_cmd, req_bg, req_ba, req_bc4, req_valid} = {c, g, b, k, 1'b1};
      while (req_ready_reg !== 1'b1) @(negedge mclk);
      @(negedge mclk);
   endtask
   // Expected launch gap of a pair whose history has fully elapsed, rounded to memory clocks.
   function automatic int exp_gap(input logic [1:0] a, b, ga, gb, input logic k);
      int s, t;
      logic same;
      same = cfg_x16 ? ga[0] == gb[0] : ga == gb;
      s = 4;
      t = 0;
      if (a == `BGCS_CMD_ACT && b == `BGCS_CMD_ACT) s = 16;
      if ((a ^ b) != 2'h0 || a != b) t = 0;
      if ((a[0] ^ a[1]) && (b[0] ^ b[1])) s = 16;
      if (a == `BGCS_CMD_WR && b == `BGCS_CMD_RD)
         t = (cfg_cwl + (cfg_bl_mode == `BGCS_BL_FIXED4 ? 2 : 4)) * 4 + (same ? 16 : 8);
      if (a == `BGCS_CMD_RD && b == `BGCS_CMD_WR)
         t = (int'(cfg_cl) - int'(cfg_cwl) + (cfg_bl_mode == `BGCS_BL_FIXED4 ||
             cfg_bl_mode == `BGCS_BL_OTF && k ? 2 : 4) + 1 + (cfg_wpre2 ? 2 : 1)) * 4;
      if (t > s) s = t;
      return (s + 3) / 4 * 4;
   endfunction
   task automatic tally_and_finish;
      if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {req_valid, req_cmd, req_bg, req_ba, req_bc4, cfg_wpre2, cfg_x16, cfg_bl_mode} = '0;
      {cfg_cl, cfg_cwl} = {5'h0b, 5'h09};
      rst = 1;
      r = $urandom(32'h989183ea);
      repeat (12) @(negedge mclk);
      check(dram_cmd_reg, `BGCS_CMD_OTHER);
      check({dram_a12_reg, dram_cmd_valid_reg, cmd_issued_reg, req_ready_reg, dram_ck}, 8'h10);
      rst = 0;
      // The hold reports room at the first edge after release.
      @(negedge mclk);
      check(req_ready_reg, 8'h01);
      for (i = 0; i < 40; i++) begin
         r = $urandom;
         q = $urandom;
         cfg_cl = (i == 1) ? 5'h09 : 5'h09 + r[3:0];
         cfg_cwl = (i == 1) ? 5'h18 : 5'h09 + r[7:4];
         cfg_bl_mode = (i == 0 || r[9:8] == 2'h3) ? `BGCS_BL_FIXED4 : r[9:8];
         cfg_wpre2 = r[10];
         cfg_x16 = r[11] || i == 2;
         if (i % 4 == 0) q[3:0] = {`BGCS_CMD_RD, `BGCS_CMD_WR};
         if (i % 4 == 1) q[3:0] = {`BGCS_CMD_WR, `BGCS_CMD_RD};
         if (i == 2) q[7:0] = 8'h25;
         @(negedge mclk);
         send(q[1:0], q[5:4], q[9:8], q[12]);
         send(q[3:2], q[7:6], q[11:10], q[13]);
         req_valid = 0;
         repeat (200) @(negedge mclk);
         check(8'(gap), 8'(exp_gap(q[1:0], q[3:2], q[5:4], q[7:6], q[12])));
         check(bank, {cfg_x16 ? 1'b0 : q[7], q[6], q[11:10]});
      end
      check(8'(seen), 8'(n_iss));
      tally_and_finish;
   end
   initial begin
      #400000;
      n_errors++;
      tally_and_finish;
   end
endmodule // tb
